/* File: rtl/dacd_decoder.sv */
`timescale 1ns/1ps
module dacd_decoder (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_n,
	// Host write port.
	input wire logic wr_strobe,
	input wire logic dc_select,
	input wire logic [7:0] wr_byte,
	// Configuration outputs.
	output dacd_pkg::dacd_mode_type addr_mode,
	output logic [6:0] page_col_start,
	output logic [6:0] col_start,
	output logic [6:0] col_end,
	output logic [2:0] page_start,
	output logic [2:0] page_end,
	output logic [5:0] start_line,
	// Effective window seen by the RAM address generator.
	output logic [6:0] win_col_lo,
	output logic [6:0] win_col_hi,
	output logic [2:0] win_page_lo,
	output logic [2:0] win_page_hi,
	output logic cmd_busy
);
	typedef enum logic [2:0] {
		IDLE, MODE_ARG, COL_A, COL_B, PAGE_A, PAGE_B
	} dacd_state_type;

	dacd_byte_if bus ();
	dacd_state_type state, next_state;
	logic [3:0] col_lo;
	logic [2:0] col_hi;
	logic [6:0] arg_col;
	logic [2:0] arg_page;

	dacd_byte_sync u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wr_strobe(wr_strobe),
		.dc_select(dc_select),
		.wr_byte(wr_byte),
		.out(bus)
	);

	// Command byte decode; data bytes (select high) are not commands.
	// command select low
	wire cmd_byte = bus.valid & bus.cmd;
	wire in_idle = state == IDLE;
	wire hit_lo = cmd_byte & in_idle & (bus.data[7:4] == 4'h0);
	wire hit_hi = cmd_byte & in_idle & (bus.data[7:3] == 5'h02);
	wire hit_line = cmd_byte & in_idle & (bus.data[7:6] == 2'h1);
	wire hit_mode = cmd_byte & in_idle & (bus.data == dacd_pkg::OP_MODE);
	wire hit_col = cmd_byte & in_idle & (bus.data == dacd_pkg::OP_COL_RANGE);
	wire hit_page = cmd_byte & in_idle &
		(bus.data == dacd_pkg::OP_PAGE_RANGE);

	// Parameter strobes, one per waiting state. Any byte taken here is a
	// parameter, even one that would decode as an opcode in IDLE.
	wire take_mode = cmd_byte & (state == MODE_ARG);
	wire take_col_a = cmd_byte & (state == COL_A);
	wire take_col_b = cmd_byte & (state == COL_B);
	wire take_page_a = cmd_byte & (state == PAGE_A);
	wire take_page_b = cmd_byte & (state == PAGE_B);

	// Parameter sequencer: one state per expected byte.
	// parameters in order
	always_comb begin
		next_state = state;
		if (cmd_byte) begin
			unique case (state)
				IDLE: begin
					if (hit_mode)
						next_state = MODE_ARG;
					else if (hit_col)
						next_state = COL_A;
					else if (hit_page)
						next_state = PAGE_A;
				end
				MODE_ARG: next_state = IDLE;
				COL_A: next_state = COL_B;
				COL_B: next_state = IDLE;
				PAGE_A: next_state = PAGE_B;
				PAGE_B: next_state = IDLE;
				default: next_state = IDLE; // Unused codes recover.
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			state <= IDLE;
		else
			state <= next_state;
	end

	// Next values of the page-mode column start nibbles. The upper nibble
	// only ever holds three bits, so its top bit is not stored at all.
	// low nibble load
	wire [3:0] next_col_lo = hit_lo ? bus.data[3:0] : col_lo;
	wire [2:0] next_col_hi = hit_hi ? bus.data[2:0] : col_hi;

	// Page-mode column start nibbles; kept apart from the window
	// registers, so a nibble command never moves the horizontal or
	// vertical column window.
	// nibble reset
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			col_lo <= dacd_pkg::RST_COL_NIBBLE;
			col_hi <= dacd_pkg::RST_COL_NIBBLE[2:0];
		end else begin
			col_lo <= next_col_lo;
			col_hi <= next_col_hi;
		end
	end

	// The page-mode column start seen by the address generator.
	assign page_col_start = {col_hi, col_lo};

	// Next addressing mode. An illegal 11b is stored as given: the host
	// must not send it, and the windows fall back to page behaviour.
	// mode select
	wire [1:0] mode_arg = bus.data[1:0];
	dacd_pkg::dacd_mode_type next_addr_mode;
	assign next_addr_mode = take_mode ?
		dacd_pkg::dacd_mode_type'(mode_arg) : addr_mode;

	// Addressing mode register; page mode out of reset.
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			addr_mode <= dacd_pkg::DACD_MODE_PAGE;
		else
			addr_mode <= next_addr_mode;
	end

	// First parameters are parked until the second one arrives.
	// collect in order
	wire [6:0] next_arg_col = take_col_a ? bus.data[6:0] : arg_col;
	wire [2:0] next_arg_page = take_page_a ? bus.data[2:0] : arg_page;

	// Parking registers for the first parameter of each window command.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			arg_col <= dacd_pkg::RST_COL_START;
			arg_page <= dacd_pkg::RST_PAGE_START;
		end else begin
			arg_col <= next_arg_col;
			arg_page <= next_arg_page;
		end
	end

	// Column window registers update together on the last parameter,
	// so the address generator never sees a half-written window. The
	// top bit of each parameter byte is dropped.
	// column window
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			col_start <= dacd_pkg::RST_COL_START;
			col_end <= dacd_pkg::RST_COL_END;
		end else if (take_col_b) begin
			col_start <= arg_col;
			col_end <= bus.data[6:0];
		end
	end

	// Page window registers, updated together in the same way; only the
	// three low bits of each parameter byte count.
	// page window
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			page_start <= dacd_pkg::RST_PAGE_START;
			page_end <= dacd_pkg::RST_PAGE_END;
		end else if (take_page_b) begin
			page_start <= arg_page;
			page_end <= bus.data[2:0];
		end
	end

	// Next display start line from the low six bits of a 40h-7Fh byte.
	// start line load
	wire [5:0] next_start_line = hit_line ? bus.data[5:0] : start_line;

	// Display start line register; line zero after every reset.
	// reset to zero
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			start_line <= dacd_pkg::RST_START_LINE;
		else
			start_line <= next_start_line;
	end

	// Page mode ignores the windows: full column span from the start
	// nibbles, and the whole page range. The invalid mode 11b falls back
	// to page behaviour rather than to a stale window.
	// window by mode
	wire use_win = addr_mode == dacd_pkg::DACD_MODE_HORIZ ||
		addr_mode == dacd_pkg::DACD_MODE_VERT;
	assign win_col_lo = use_win ? col_start : page_col_start;
	assign win_col_hi = use_win ? col_end : dacd_pkg::RST_COL_END;
	assign win_page_lo = use_win ? page_start : dacd_pkg::RST_PAGE_START;
	assign win_page_hi = use_win ? page_end : dacd_pkg::RST_PAGE_END;

	// Busy while parameter bytes are still awaited.
	// parameter wait
	assign cmd_busy = !in_idle;
endmodule

/* File: rtl/dacd_pkg.sv */
package dacd_pkg;
	// Addressing modes selected by the mode command parameter.
	typedef enum logic [1:0] {
		DACD_MODE_HORIZ = 2'h0,
		DACD_MODE_VERT = 2'h1,
		DACD_MODE_PAGE = 2'h2,
		DACD_MODE_BAD = 2'h3
	} dacd_mode_type;

	// Opcodes of the multi-byte commands.
	localparam logic [7:0] OP_MODE = 8'h20;
	localparam logic [7:0] OP_COL_RANGE = 8'h21;
	localparam logic [7:0] OP_PAGE_RANGE = 8'h22;

	// Values after reset.
	localparam logic [3:0] RST_COL_NIBBLE = 4'h0;
	localparam logic [6:0] RST_COL_START = 7'h00;
	localparam logic [6:0] RST_COL_END = 7'h7F;
	localparam logic [2:0] RST_PAGE_START = 3'h0;
	localparam logic [2:0] RST_PAGE_END = 3'h7;
	localparam logic [5:0] RST_START_LINE = 6'h00;
endpackage

/* File: rtl/dacd_byte_if.sv */
`timescale 1ns/1ps
// Carries one written byte and its command/data qualifier.
interface dacd_byte_if;
	logic valid;
	logic cmd;
	logic [7:0] data;
	modport src (output valid, output cmd, output data);
	modport dst (input valid, input cmd, input data);
endinterface

/* File: rtl/dacd_byte_sync.sv */
`timescale 1ns/1ps
// Brings the host strobe into sys_clk and emits one byte per rising edge.
module dacd_byte_sync (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_n,
	// Host side, asynchronous.
	input wire logic wr_strobe,
	input wire logic dc_select,
	input wire logic [7:0] wr_byte,
	// Synchronised byte.
	dacd_byte_if.src out
);
	logic [2:0] strobe_sync;
	logic [7:0] byte_meta;
	logic [7:0] byte_sync;
	logic dc_meta;
	logic dc_sync;
	logic [7:0] byte_hold;
	logic dc_hold;
	logic valid;

	// A rising strobe, seen once it has passed two flops.
	wire strobe_rise = strobe_sync[1] & ~strobe_sync[2];

	// Byte and select pass two flops beside the strobe. The host must set
	// them up before the strobe rises, since both are sampled together.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			strobe_sync <= 3'h0;
			byte_meta <= 8'h00;
			byte_sync <= 8'h00;
			dc_meta <= 1'b0;
			dc_sync <= 1'b0;
		end else begin
			strobe_sync <= {strobe_sync[1:0], wr_strobe};
			byte_meta <= wr_byte;
			byte_sync <= byte_meta;
			dc_meta <= dc_select;
			dc_sync <= dc_meta;
		end
	end

	// The byte is held until the next strobe edge; valid lasts one cycle.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			byte_hold <= 8'h00;
			dc_hold <= 1'b0;
			valid <= 1'b0;
		end else begin
			valid <= strobe_rise;
			if (strobe_rise) begin
				byte_hold <= byte_sync;
				dc_hold <= dc_sync;
			end
		end
	end

	assign out.valid = valid;
	assign out.cmd = ~dc_hold;
	assign out.data = byte_hold;
endmodule

/* File: verification/dacd_decoder_props.sv */
`timescale 1ns/1ps
// Reset values and the window handed to the address generator.
module dacd_decoder_props (
	// Clock and reset.
	input logic sys_clk,
	input logic rst_n,
	// Registers and window.
	input dacd_pkg::dacd_mode_type addr_mode,
	input logic [6:0] page_col_start,
	input logic [6:0] col_start,
	input logic [6:0] col_end,
	input logic [2:0] page_start,
	input logic [2:0] page_end,
	input logic [5:0] start_line,
	input logic [6:0] win_col_lo,
	input logic [6:0] win_col_hi,
	input logic [2:0] win_page_lo,
	input logic [2:0] win_page_hi,
	// Sequencer.
	input logic cmd_busy
);
	// One clock; nothing is judged while reset holds.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_rmode; $rose(rst_n) |-> addr_mode == 2'h2; endproperty
	a_rmode: assert property (p_rmode) else $error("mode reset");
	property p_rpcs; $rose(rst_n) |-> page_col_start == 7'h00; endproperty
	a_rpcs: assert property (p_rpcs) else $error("column reset");
	property p_rcol; $rose(rst_n) |-> {col_start, col_end} == 14'h007F;
	endproperty
	a_rcol: assert property (p_rcol) else $error("window reset");
	property p_rpg; $rose(rst_n) |-> {page_start, page_end} == 6'h07;
	endproperty
	a_rpg: assert property (p_rpg) else $error("page reset");
	property p_rline; $rose(rst_n) |-> start_line == 6'h00; endproperty
	a_rline: assert property (p_rline) else $error("line reset");
	property p_pwin; addr_mode == 2'h2 |->
		{win_col_lo, win_col_hi} == {page_col_start, 7'h7F}; endproperty
	a_pwin: assert property (p_pwin) else $error("page window");
	property p_hwin; addr_mode < 2'h2 |->
		{win_page_lo, win_page_hi} == {page_start, page_end}; endproperty
	a_hwin: assert property (p_hwin) else $error("hv window");
	property p_nib; $changed(page_col_start) |-> $stable({col_start, col_end});
	endproperty
	a_nib: assert property (p_nib) else $error("nibble hit window");
	property p_rbusy; $rose(rst_n) |-> !cmd_busy; endproperty
	a_rbusy: assert property (p_rbusy) else $error("busy reset");
	property p_hcol; addr_mode < 2'h2 |->
		{win_col_lo, win_col_hi} == {col_start, col_end}; endproperty
	a_hcol: assert property (p_hcol) else $error("hv columns");
	property p_ppg; addr_mode == 2'h2 |->
		{win_page_lo, win_page_hi} == 6'h07; endproperty
	a_ppg: assert property (p_ppg) else $error("page pages");
endmodule

/* File: verification/dacd_host_model.sv */
`timescale 1ns/1ps
// Host side: one byte per slow strobe.
module dacd_host_model (
	// Clock.
	input wire logic sys_clk,
	// Write pins.
	output logic wr_strobe,
	output logic dc_select,
	output logic [7:0] wr_byte
);
	initial {wr_strobe, dc_select, wr_byte} = 10'h100;
	// ordered low-select bytes
	// Strobe stands four cycles each way; idle pins show inverted garbage.
	task automatic put(input logic [7:0] b, input logic dc = 1'b0);
		@(posedge sys_clk) #1 {wr_strobe, dc_select, wr_byte} = {1'b1, dc, b};
		repeat (4) @(posedge sys_clk);
		#1 {wr_strobe, dc_select, wr_byte} = {1'b0, ~dc, ~b};
		repeat (3) @(posedge sys_clk);
	endtask
endmodule

/* File: verification/display_address_cmd_decoder_test.sv */
`timescale 1ns/1ps
// Random addressing commands; register snapshot checked after each.
module display_address_cmd_decoder_test;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	wire wr_strobe, dc_select, cmd_busy;
	wire [7:0] wr_byte;
	wire [1:0] addr_mode;
	wire [6:0] page_col_start, col_start, col_end, win_col_lo, win_col_hi;
	wire [2:0] page_start, page_end, win_page_lo, win_page_hi;
	wire [5:0] start_line;
	wire [35:0] seen = {cmd_busy, addr_mode, page_col_start, col_start,
		col_end, page_start, page_end, start_line};
	wire [19:0] win = {win_col_lo, win_col_hi, win_page_lo, win_page_hi};
	logic [35:0] m;
	logic [35:0] e;
	logic [35:0] exp_q[$];
	logic [31:0] seed = 32'hFAA1;
	int fails = 0;
	int n_tests = 0;
	event shown;
	always #2.5 sys_clk = ~sys_clk;
	dacd_host_model host (.*);
	dacd_decoder dut (.*);
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic check(input logic [35:0] e, g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH regs exp %h got %h", e, g);
		end
	endtask
	task automatic check_win(input logic [19:0] e, g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH window exp %h got %h", e, g);
		end
	endtask
	task automatic report_and_stop();
		if (fails == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Reset held five cycles; every register must be back at its default.
	task automatic do_reset();
		#1 rst_n = 1'b0;
		repeat (5) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		m = {1'b0, 2'h2, 14'h0000, 7'h7F, 6'h07, 6'h00};
		note(1'b0);
	endtask
	// One expected snapshot; busy says whether parameters are awaited.
	task automatic note(input logic busy);
		m[35] = busy;
		exp_q.push_back(m);
		-> shown;
	endtask
	// Kind k: nibbles, mode, windows, start line; 6 is a data byte.
	task automatic cmd(input int k);
		logic [7:0] a, b;
		a = rnd();
		b = seed[15:8];
		if (k == 2) a[1] = a[1] & ~a[0];
		case (k)
		0: host.put({4'h0, a[3:0]});
		1: host.put({5'h02, a[2:0]});
		5: host.put({2'h1, a[5:0]});
		6: host.put(a, 1'b1);
		default: host.put(8'h1E + k[7:0]);
		endcase
		// Parameters are full random bytes save the mode one, whose low bits are never 11b, so masking is tested too.
		if (k > 1 && k < 5) begin
			note(1'b1);
			host.put(a);
		end
		if (k > 2 && k < 5) begin
			note(1'b1);
			host.put(b);
		end
		case (k)
		0: m[29:26] = a[3:0];
		1: m[32:30] = a[2:0];
		2: m[34:33] = a[1:0];
		3: m[25:12] = {a[6:0], b[6:0]};
		4: m[11:6] = {a[2:0], b[2:0]};
		5: m[5:0] = a[5:0];
		default: ;
		endcase
		note(1'b0);
	endtask
	initial begin
		do_reset();
		for (int i = 0; i < 60; i++) begin
			cmd(i < 7 ? i : int'(rnd()) % 7);
		end
		// A window command cut by reset must leave nothing pending.
		host.put(dacd_pkg::OP_COL_RANGE);
		do_reset();
		cmd(3);
		repeat (2) @(posedge sys_clk);
		report_and_stop();
	end
	// Outputs have settled long before each note is taken.
	initial forever begin
		@(shown);
		#1 e = exp_q.pop_front();
		check(e, seen);
		check_win(e[34] ? {e[32:26], 7'h7F, 6'h07} : e[25:6], win);
	end
	// The run needs under ten microseconds; a hang is cut well after.
	initial begin
		#60us;
		fails++;
		report_and_stop();
	end
endmodule
bind dacd_decoder dacd_decoder_props chk (.*);
